// ===== pkg/lbt_pkg.sv
// lbt_pkg: register map, field layout and encodings of the loopback and
// transmit buffer control block; shared by every lbt design file.
package lbt_pkg;

    localparam int unsigned          LBT_ADDR_W       = 8;
    localparam int unsigned          LBT_DATA_W       = 32;

    // register byte offsets
    localparam logic [7:0]           LBT_LOOP_OFS     = 8'h44;
    localparam logic [7:0]           LBT_TXDLY_OFS    = 8'h48;

    // loop_path_select fields
    localparam int unsigned          LBT_FWD_LSB      = 0;
    localparam int unsigned          LBT_FWD_W        = 2;
    localparam int unsigned          LBT_REV_LSB      = 8;
    localparam int unsigned          LBT_REV_W        = 3;

    // tx_buffer_delay_control fields
    localparam int unsigned          LBT_REALIGN_BIT  = 8;
    localparam int unsigned          LBT_FILL_LSB     = 0;
    localparam int unsigned          LBT_FILL_W       = 4;

    // reverse loopback codes
    localparam logic [2:0]           LBT_REV_OFF      = 3'h0;
    localparam logic [2:0]           LBT_REV_FULL     = 3'h1;
    localparam logic [2:0]           LBT_REV_IQ       = 3'h2;
    localparam logic [2:0]           LBT_REV_FAST     = 3'h3;
    localparam logic [2:0]           LBT_REV_FAST_VS  = 3'h4;

    // forward loopback codes
    localparam logic [1:0]           LBT_FWD_OFF      = 2'h0;
    localparam logic [1:0]           LBT_FWD_PMA      = 2'h1;
    localparam logic [1:0]           LBT_FWD_EXDLY    = 2'h2;
    localparam logic [1:0]           LBT_FWD_FRAME    = 2'h3;

    // received word class, tagged by the deframer
    localparam logic [1:0]           LBT_CLS_OTHER    = 2'h0;
    localparam logic [1:0]           LBT_CLS_FAST     = 2'h1;
    localparam logic [1:0]           LBT_CLS_VENDOR   = 2'h2;

    // reset values
    localparam logic [31:0]          LBT_RST_WORD     = 32'h0000_0000;

    // axi responses
    localparam logic [1:0]           LBT_RESP_OKAY    = 2'h0;
    localparam logic [1:0]           LBT_RESP_SLVERR  = 2'h2;

    typedef enum logic [1:0] {
        LBT_WR_IDLE = 2'b01,
        LBT_WR_RESP = 2'b10
    } lbt_wr_state_t;

    typedef enum logic [1:0] {
        LBT_RD_IDLE = 2'b01,
        LBT_RD_RESP = 2'b10
    } lbt_rd_state_t;

endpackage : lbt_pkg

// ===== verilog/lbt_word_select.sv
// lbt_word_select: decides per outgoing word whether the received word is
// echoed or the locally built word is sent, from the reverse loopback code.
// assumes received and local words are aligned to the same frame position.
`timescale 1ns/1ps

module lbt_word_select
    import lbt_pkg::*;
(
    input  wire logic [2:0]  rev_mode,
    input  wire logic        rx_is_ctrl,
    input  wire logic [1:0]  rx_class,
    input  wire logic [31:0] rx_word,
    input  wire logic [31:0] local_word,
    output wire logic        echo,
    output wire logic [31:0] out_word
);

    wire logic is_fast;
    wire logic is_vendor;
    wire logic pick_full;
    wire logic pick_iq;
    wire logic pick_fast;
    wire logic pick_fast_vs;

    assign is_fast      = (rx_class == LBT_CLS_FAST);
    assign is_vendor    = (rx_class == LBT_CLS_VENDOR);
    assign pick_full    = (rev_mode == LBT_REV_FULL);
    assign pick_iq      = (rev_mode == LBT_REV_IQ) && !rx_is_ctrl;
    assign pick_fast    = (rev_mode == LBT_REV_FAST) && is_fast;
    assign pick_fast_vs = (rev_mode == LBT_REV_FAST_VS) && rx_is_ctrl
                          && (is_fast || is_vendor);

    assign echo     = pick_full || pick_iq || pick_fast || pick_fast_vs;
    assign out_word = echo ? rx_word : local_word;

endmodule : lbt_word_select

// ===== verilog/lbt_loop_ctrl.sv
// lbt_loop_ctrl: axi4-lite register bank for loopback path selection and
// transmit buffer pointer realignment, with the reverse loopback word mux.
// assumes one clock for bus and datapath; datapath inputs are synchronous.
//
// Operation
// - reverse code 0 sends only local words, code 1 echoes every received word unchanged.
// - reverse code 2 echoes received data words and builds all control words locally.
// - reverse code 3 echoes fast management words and builds every other word locally.
// - reverse code 4 echoes fast management and vendor control words, the rest is local.
// - forward code 0 is no loopback, code 1 is the serial pma loop if that option is built.
// - forward code 2 loops through the extended delay logic, only with the parallel option.
// - forward code 3 loops through framing logic only, only with the parallel option.
// - the forward field is two rw bits at 1:0, resets to zero and shows the active path.
// - a 0 to 1 change of bit 8 of the tx delay register forces a tx buffer pointer realignment.
// - a line bit rate change realigns the tx buffer pointers without software.
// - bits 3:0 of the tx delay register read the present tx buffer fill level.
`timescale 1ns/1ps

module lbt_loop_ctrl
    import lbt_pkg::*;
#(
    parameter bit HAS_PAR_REV = 1'b1,
    parameter bit HAS_SER_FWD = 1'b1,
    parameter bit HAS_PAR_FWD = 1'b1,
    parameter int RATE_W      = 4
)(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output wire logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output wire logic              s_axi_wready,
    output wire logic [1:0]        s_axi_bresp,
    output wire logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output wire logic              s_axi_arready,
    output wire logic [31:0]       s_axi_rdata,
    output wire logic [1:0]        s_axi_rresp,
    output wire logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [31:0]       rx_word,
    input  wire logic              rx_word_valid,
    input  wire logic              rx_word_is_ctrl,
    input  wire logic [1:0]        rx_word_class,
    input  wire logic [31:0]       local_word,
    output wire logic [31:0]       tx_word,
    output wire logic              tx_word_valid,
    output wire logic              tx_word_looped,
    input  wire logic [RATE_W-1:0] line_rate,
    input  wire logic [3:0]        tx_fill_level,
    output wire logic              fwd_pma_loop,
    output wire logic              fwd_exdly_loop,
    output wire logic              fwd_frame_loop,
    output wire logic              tx_pointer_realign
);

    // codes whose option is not built are stored as zero, so a read
    // always shows the path that is really active
    function automatic logic [1:0] fwd_legal(input logic [1:0] code);
        logic [1:0] res;
        res = LBT_FWD_OFF;
        if (code == LBT_FWD_PMA && HAS_SER_FWD) begin
            res = code;
        end else if ((code == LBT_FWD_EXDLY || code == LBT_FWD_FRAME) && HAS_PAR_FWD) begin
            res = code;
        end
        return res;
    endfunction : fwd_legal

    function automatic logic [2:0] rev_legal(input logic [2:0] code);
        logic [2:0] res;
        res = LBT_REV_OFF;
        if (HAS_PAR_REV && code <= LBT_REV_FAST_VS) begin
            res = code;
        end
        return res;
    endfunction : rev_legal

    // reset release
    logic rst_meta_ff;
    logic rst_n;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    // write channel
    lbt_wr_state_t wr_state_ff;
    logic          awready_ff;
    logic          wready_ff;
    logic          aw_held_ff;
    logic          w_held_ff;
    logic [7:0]    awaddr_ff;
    logic [31:0]   wdata_ff;
    logic [3:0]    wstrb_ff;
    logic          bvalid_ff;
    logic [1:0]    bresp_ff;

    wire logic        aw_take;
    wire logic        w_take;
    wire logic        aw_have;
    wire logic        w_have;
    wire logic        do_write;
    wire logic        b_done;
    wire logic [7:0]  wr_addr;
    wire logic [31:0] wr_data;
    wire logic [3:0]  wr_strb;
    wire logic        wr_loop;
    wire logic        wr_txdly;

    assign aw_take  = s_axi_awvalid && awready_ff;
    assign w_take   = s_axi_wvalid && wready_ff;
    assign aw_have  = aw_held_ff || aw_take;
    assign w_have   = w_held_ff || w_take;
    assign do_write = (wr_state_ff == LBT_WR_IDLE) && aw_have && w_have;
    assign b_done   = bvalid_ff && s_axi_bready;
    assign wr_addr  = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data  = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_strb  = w_held_ff ? wstrb_ff : s_axi_wstrb;
    assign wr_loop  = do_write && (wr_addr == LBT_LOOP_OFS);
    assign wr_txdly = do_write && (wr_addr == LBT_TXDLY_OFS);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_ff <= LBT_WR_IDLE;
            awready_ff  <= 1'b1;
            wready_ff   <= 1'b1;
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= LBT_RESP_OKAY;
        end else if (do_write) begin
            wr_state_ff <= LBT_WR_RESP;
            awready_ff  <= 1'b0;
            wready_ff   <= 1'b0;
            aw_held_ff  <= 1'b0;
            w_held_ff   <= 1'b0;
            bvalid_ff   <= 1'b1;
            bresp_ff    <= (wr_loop || wr_txdly) ? LBT_RESP_OKAY : LBT_RESP_SLVERR;
        end else if (b_done) begin
            wr_state_ff <= LBT_WR_IDLE;
            awready_ff  <= 1'b1;
            wready_ff   <= 1'b1;
            bvalid_ff   <= 1'b0;
        end else begin
            if (aw_take) begin
                awready_ff <= 1'b0;
                aw_held_ff <= 1'b1;
            end
            if (w_take) begin
                wready_ff <= 1'b0;
                w_held_ff <= 1'b1;
            end
        end
    end

    // payload capture, no reset needed beyond a defined value
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            awaddr_ff <= '0;
            wdata_ff  <= LBT_RST_WORD;
            wstrb_ff  <= '0;
        end else begin
            if (aw_take) awaddr_ff <= s_axi_awaddr;
            if (w_take) wdata_ff <= s_axi_wdata;
            if (w_take) wstrb_ff <= s_axi_wstrb;
        end
    end

    // control registers
    logic [1:0]          fwd_mode_ff;
    logic [2:0]          rev_mode_ff;
    logic                realign_req_ff;
    logic                realign_req_prev_ff;
    logic [3:0]          fill_ff;
    logic [RATE_W-1:0]   rate_prev_ff;
    logic                realign_ff;
    logic                fwd_pma_ff;
    logic                fwd_exdly_ff;
    logic                fwd_frame_ff;

    wire logic [1:0] nxt_fwd_mode;
    wire logic [2:0] nxt_rev_mode;
    wire logic       nxt_realign_req;
    wire logic       rate_changed;
    wire logic       nxt_realign;

    // only the defined fields take write data, reserved bits are dropped
    assign nxt_fwd_mode    = (wr_loop && wr_strb[0])
                             ? fwd_legal(wr_data[LBT_FWD_LSB +: LBT_FWD_W])
                             : fwd_mode_ff;
    assign nxt_rev_mode    = (wr_loop && wr_strb[1])
                             ? rev_legal(wr_data[LBT_REV_LSB +: LBT_REV_W])
                             : rev_mode_ff;
    assign nxt_realign_req = (wr_txdly && wr_strb[1])
                             ? wr_data[LBT_REALIGN_BIT]
                             : realign_req_ff;
    assign rate_changed    = (line_rate != rate_prev_ff);
    // pulse on a fresh software request or on any rate change
    assign nxt_realign     = (realign_req_ff && !realign_req_prev_ff)
                             || rate_changed;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_mode_ff         <= LBT_FWD_OFF;
            rev_mode_ff         <= LBT_REV_OFF;
            realign_req_ff      <= 1'b0;
            realign_req_prev_ff <= 1'b0;
            fill_ff             <= '0;
            rate_prev_ff        <= '0;
            realign_ff          <= 1'b0;
            fwd_pma_ff          <= 1'b0;
            fwd_exdly_ff        <= 1'b0;
            fwd_frame_ff        <= 1'b0;
        end else begin
            fwd_mode_ff         <= nxt_fwd_mode;
            rev_mode_ff         <= nxt_rev_mode;
            realign_req_ff      <= nxt_realign_req;
            realign_req_prev_ff <= realign_req_ff;
            fill_ff             <= tx_fill_level;
            rate_prev_ff        <= line_rate;
            realign_ff          <= nxt_realign;
            fwd_pma_ff          <= (fwd_mode_ff == LBT_FWD_PMA);
            fwd_exdly_ff        <= (fwd_mode_ff == LBT_FWD_EXDLY);
            fwd_frame_ff        <= (fwd_mode_ff == LBT_FWD_FRAME);
        end
    end

    // read channel
    lbt_rd_state_t rd_state_ff;
    logic          arready_ff;
    logic          rvalid_ff;
    logic [31:0]   rdata_ff;
    logic [1:0]    rresp_ff;
    logic [31:0]   rd_word;
    logic          rd_hit;

    wire logic ar_take;
    wire logic r_done;

    assign ar_take = s_axi_arvalid && arready_ff;
    assign r_done  = rvalid_ff && s_axi_rready;

    always_comb begin
        rd_word = LBT_RST_WORD;
        rd_hit  = 1'b0;
        if (s_axi_araddr == LBT_LOOP_OFS) begin
            rd_word[LBT_FWD_LSB +: LBT_FWD_W] = fwd_mode_ff;
            rd_word[LBT_REV_LSB +: LBT_REV_W] = rev_mode_ff;
            rd_hit = 1'b1;
        end else if (s_axi_araddr == LBT_TXDLY_OFS) begin
            rd_word[LBT_FILL_LSB +: LBT_FILL_W] = fill_ff;
            rd_word[LBT_REALIGN_BIT]            = realign_req_ff;
            rd_hit = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_ff <= LBT_RD_IDLE;
            arready_ff  <= 1'b1;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= LBT_RST_WORD;
            rresp_ff    <= LBT_RESP_OKAY;
        end else begin
            case (rd_state_ff)
                LBT_RD_IDLE: begin
                    if (ar_take) begin
                        rd_state_ff <= LBT_RD_RESP;
                        arready_ff  <= 1'b0;
                        rvalid_ff   <= 1'b1;
                        rdata_ff    <= rd_word;
                        rresp_ff    <= rd_hit ? LBT_RESP_OKAY : LBT_RESP_SLVERR;
                    end
                end
                LBT_RD_RESP: begin
                    if (r_done) begin
                        rd_state_ff <= LBT_RD_IDLE;
                        arready_ff  <= 1'b1;
                        rvalid_ff   <= 1'b0;
                    end
                end
                default: begin
                    rd_state_ff <= LBT_RD_IDLE;
                    arready_ff  <= 1'b1;
                    rvalid_ff   <= 1'b0;
                end
            endcase
        end
    end

    // reverse loopback word path, one register stage
    logic [31:0] tx_word_ff;
    logic        tx_valid_ff;
    logic        tx_looped_ff;

    wire logic        sel_echo;
    wire logic [31:0] sel_word;

    lbt_word_select u_word_select (
        .rev_mode   (rev_mode_ff),
        .rx_is_ctrl (rx_word_is_ctrl),
        .rx_class   (rx_word_class),
        .rx_word    (rx_word),
        .local_word (local_word),
        .echo       (sel_echo),
        .out_word   (sel_word)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_word_ff   <= LBT_RST_WORD;
            tx_valid_ff  <= 1'b0;
            tx_looped_ff <= 1'b0;
        end else begin
            tx_word_ff   <= sel_word;
            tx_valid_ff  <= rx_word_valid;
            tx_looped_ff <= sel_echo && rx_word_valid;
        end
    end

    assign s_axi_awready      = awready_ff;
    assign s_axi_wready       = wready_ff;
    assign s_axi_bvalid       = bvalid_ff;
    assign s_axi_bresp        = bresp_ff;
    assign s_axi_arready      = arready_ff;
    assign s_axi_rvalid       = rvalid_ff;
    assign s_axi_rdata        = rdata_ff;
    assign s_axi_rresp        = rresp_ff;
    assign tx_word            = tx_word_ff;
    assign tx_word_valid      = tx_valid_ff;
    assign tx_word_looped     = tx_looped_ff;
    assign fwd_pma_loop       = fwd_pma_ff;
    assign fwd_exdly_loop     = fwd_exdly_ff;
    assign fwd_frame_loop     = fwd_frame_ff;
    assign tx_pointer_realign = realign_ff;

    // checks
    sequence seq_loop_write;
        wr_loop && wr_strb[0];
    endsequence

    sequence seq_txdly_read;
        ar_take && (s_axi_araddr == LBT_TXDLY_OFS);
    endsequence

    sequence seq_loop_read;
        ar_take && (s_axi_araddr == LBT_LOOP_OFS);
    endsequence

    chk_rev_off_local: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rx_word_valid && rev_mode_ff == LBT_REV_OFF)
        |=> (!tx_looped_ff && tx_word_ff == $past(local_word)))
        else $error("reverse loop off but word echoed");

    chk_rev_full_echo: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rx_word_valid && rev_mode_ff == LBT_REV_FULL)
        |=> (tx_looped_ff && tx_word_ff == $past(rx_word)))
        else $error("full reverse loop did not echo word");

    chk_rev_iq_ctrl: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rx_word_valid && rev_mode_ff == LBT_REV_IQ)
        |=> (tx_looped_ff == !$past(rx_word_is_ctrl)))
        else $error("iq reverse loop chose wrong word");

    chk_rev_fast_word: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rx_word_valid && rev_mode_ff == LBT_REV_FAST)
        |=> (tx_looped_ff == ($past(rx_word_class) == LBT_CLS_FAST)))
        else $error("fast reverse loop chose wrong word");

    chk_rev_vendor_ctrl: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (rx_word_valid && rev_mode_ff == LBT_REV_FAST_VS && !rx_word_is_ctrl)
        |=> !tx_looped_ff)
        else $error("vendor reverse loop echoed a data word");

    chk_fwd_path_decode: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $stable(fwd_mode_ff)
        |-> ({fwd_frame_ff, fwd_exdly_ff, fwd_pma_ff} ==
             {fwd_mode_ff == LBT_FWD_FRAME, fwd_mode_ff == LBT_FWD_EXDLY,
              fwd_mode_ff == LBT_FWD_PMA}))
        else $error("forward path outputs disagree with mode");

    chk_fwd_par_only: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (fwd_exdly_ff || fwd_frame_ff) |-> HAS_PAR_FWD)
        else $error("parallel forward path without option");

    chk_fwd_write_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        seq_loop_write |=> (fwd_mode_ff == fwd_legal($past(wr_data[1:0]))) ##1
        ((fwd_mode_ff == LBT_FWD_FRAME) == fwd_frame_ff))
        else $error("forward field write not applied");

    chk_realign_sw: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (realign_req_ff && !realign_req_prev_ff) |=> realign_ff)
        else $error("software realign gave no pulse");

    chk_realign_rate: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (line_rate != $past(line_rate)) |-> ##1 realign_ff)
        else $error("rate change gave no realign");

    chk_fill_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        seq_txdly_read |=> (s_axi_rvalid && s_axi_rdata[3:0] == $past(fill_ff)
                            && s_axi_rdata[31:9] == '0 && s_axi_rdata[7:4] == '0))
        else $error("fill level read wrong");

    chk_loop_reserved: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        seq_loop_read |=> (s_axi_rdata[31:11] == '0 && s_axi_rdata[7:2] == '0))
        else $error("reserved loop bits read non-zero");

endmodule : lbt_loop_ctrl

// ===== sim/test_loopback_and_tx_buffer_control.sv
// testbench for lbt_loop_ctrl: axi4-lite register access and word path checks
// assumes one 250 mhz clock and that the design holds its own assertions
`timescale 1ns/1ps

module test_loopback_and_tx_buffer_control;
    import lbt_pkg::*;
    logic core_clk = 0, resetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rx_word = 0, local_word = 0;
    logic [3:0] wstrb = 0, line_rate = 0, fill = 4'h9;
    logic rx_valid = 0, rx_ctrl = 0;
    logic [1:0] rx_cls = 0;
    wire logic awready, wready, bvalid, arready, rvalid, tx_valid, looped, pma, exd, frm, realign;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata, tx_word;
    int n_errors = 0, total_checks = 0, n_pulse = 0, m, k, p;
    logic e;
    logic [4:0] ctl = 5'b10110;
    logic [1:0] cls [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};

    lbt_loop_ctrl dut (.core_clk(core_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_word(rx_word), .rx_word_valid(rx_valid),
        .rx_word_is_ctrl(rx_ctrl), .rx_word_class(rx_cls), .local_word(local_word),
        .tx_word(tx_word), .tx_word_valid(tx_valid), .tx_word_looped(looped),
        .line_rate(line_rate), .tx_fill_level(fill), .fwd_pma_loop(pma),
        .fwd_exdly_loop(exd), .fwd_frame_loop(frm), .tx_pointer_realign(realign));

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (realign === 1'b1) n_pulse <= n_pulse + 1;

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // called just after a rising edge; every wait is bounded
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (int n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (bvalid === 1'b1 && bready) begin
                bready <= 0;
                chk("bresp", {30'h0, er}, {30'h0, bresp});
                // one idle edge so the next call never re-raises bready in this step
                @(posedge core_clk);
                return;
            end
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
        end
        n_errors++;
        end_sim();
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (int n = 0; n < 20; n++) begin
            @(posedge core_clk);
            if (rvalid === 1'b1 && rready) begin
                rready <= 0;
                chk("rdata", ed, rdata);
                chk("rresp", {30'h0, er}, {30'h0, rresp});
                @(posedge core_clk);
                return;
            end
            if (arvalid && arready === 1'b1) arvalid <= 0;
        end
        n_errors++;
        end_sim();
    endtask : axi_rd

    initial begin
        repeat (5) @(posedge core_clk);
        resetn <= 1;
        repeat (3) @(posedge core_clk);
        axi_rd(LBT_LOOP_OFS, 32'h0, LBT_RESP_OKAY);
        axi_rd(LBT_TXDLY_OFS, 32'h9, LBT_RESP_OKAY);
        axi_wr(LBT_LOOP_OFS, 32'hffff_ffff, 4'hf, LBT_RESP_OKAY);
        axi_rd(LBT_LOOP_OFS, 32'h3, LBT_RESP_OKAY);
        axi_wr(8'h40, 32'h1, 4'hf, LBT_RESP_SLVERR);
        axi_rd(8'h4c, 32'h0, LBT_RESP_SLVERR);
        for (m = 0; m < 4; m++) begin
            axi_wr(LBT_LOOP_OFS, m, 4'hf, LBT_RESP_OKAY);
            repeat (2) @(posedge core_clk);
            chk("fwd", 1 << m, {28'h0, frm, exd, pma, ~|{frm, exd, pma}});
            axi_rd(LBT_LOOP_OFS, m, LBT_RESP_OKAY);
        end
        for (m = 0; m < 5; m++) begin
            axi_wr(LBT_LOOP_OFS, m << 8, 4'hf, LBT_RESP_OKAY);
            for (k = 0; k < 5; k++) begin
                rx_ctrl <= ctl[k]; rx_cls <= cls[k]; rx_valid <= 1;
                rx_word <= 32'ha000_0000 + k; local_word <= 32'h5000_0000 + k;
                @(posedge core_clk);
                rx_valid <= 0;
                #1;
                e = (m == 1) || (m == 2 && !ctl[k]) || (m == 3 && cls[k] == 2'h1)
                    || (m == 4 && ctl[k] && cls[k] != 2'h0);
                chk("tx_word", e ? 32'ha000_0000 + k : 32'h5000_0000 + k, tx_word);
                chk("looped", {31'h0, e}, {31'h0, looped});
                chk("tx_valid", 32'h1, {31'h0, tx_valid});
                @(posedge core_clk);
            end
        end
        p = n_pulse;
        axi_wr(LBT_TXDLY_OFS, 32'hffff_ffff, 4'hf, LBT_RESP_OKAY);
        repeat (6) @(posedge core_clk);
        chk("realign_sw", p + 1, n_pulse);
        axi_rd(LBT_TXDLY_OFS, 32'h109, LBT_RESP_OKAY);
        axi_wr(LBT_TXDLY_OFS, 32'h100, 4'hf, LBT_RESP_OKAY);
        repeat (6) @(posedge core_clk);
        chk("realign_hold", p + 1, n_pulse);
        axi_wr(LBT_TXDLY_OFS, 32'h0, 4'hf, LBT_RESP_OKAY);
        fill <= 4'h2;
        line_rate <= 4'h3;
        repeat (6) @(posedge core_clk);
        chk("realign_rate", p + 2, n_pulse);
        axi_rd(LBT_TXDLY_OFS, 32'h2, LBT_RESP_OKAY);
        end_sim();
    end
endmodule : test_loopback_and_tx_buffer_control
